// *** hw/tcm_core_port.sv ***
// Core end of the memory port: issues requests, honours wait, owns regions.
// Assumes the memory end answers on the shared link clocked by clock_i.
`timescale 1ns/100ps
module tcm_core_port (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	tcm_link_if.core link,
	input wire logic boot_imem_enable_pin_i,
	input wire logic high_vector_pin_i,
	input wire logic big_endian_i,
	input wire logic instr_side_i,
	input wire logic req_i,
	input wire logic write_i,
	input wire logic seq_i,
	input wire logic [tcm_port_pkg::ADDR_W-1:0] addr_i,
	input wire logic [1:0] byte_offset_i,
	input wire logic [1:0] size_i,
	input wire logic [tcm_port_pkg::DATA_W-1:0] wdata_i,
	input wire logic region_wr_i,
	input wire logic region_sel_i,
	input wire logic [31:0] region_wdata_i,
	output logic ack_o,
	output logic refused_o,
	output logic rvalid_o,
	output logic [tcm_port_pkg::DATA_W-1:0] rdata_o,
	output logic [31:0] itcm_region_o,
	output logic [31:0] dtcm_region_o,
	output logic [31:0] boot_addr_o
);
	logic sel_ff;
	logic waiting_ff;
	logic last_ff;
	logic acc_wr_ff;
	logic seq_ff;
	logic dir_ff;
	logic [tcm_port_pkg::ADDR_W-1:0] addr_ff;
	logic [tcm_port_pkg::LANES-1:0] bel_ff;
	logic [tcm_port_pkg::DATA_W-1:0] wd_ff;
	logic refused_ff;
	logic rvalid_ff;
	logic [tcm_port_pkg::DATA_W-1:0] rdata_ff;
	logic [31:0] itcm_ff;
	logic [31:0] dtcm_ff;
	logic [31:0] boot_ff;
	logic active;
	logic nxt_waiting;
	logic region_on;
	logic take;

	// Lane mask from byte offset and size; big endian mirrors the lanes
	function automatic logic [3:0] lane_mask(input logic [1:0] off, input logic [1:0] size,
		input logic big);
		logic [3:0] m;
		m = tcm_port_pkg::MASK_WORD;
		if (size == tcm_port_pkg::SIZE_BYTE) begin
			m = tcm_port_pkg::MASK_BYTE << off;
		end else if (size == tcm_port_pkg::SIZE_HALF) begin
			m = tcm_port_pkg::MASK_HALF << {off[1], 1'b0};
		end
		if (big) begin
			m = {m[0], m[1], m[2], m[3]}; // see (R20)
		end
		return m;
	endfunction

	// Wait only counts while an access is live; idle-cycle wait is ignored
	assign active = sel_ff | waiting_ff; // see (R2)
	assign nxt_waiting = active & link.data_mem_wait; // see (R1)
	assign region_on = instr_side_i ? itcm_ff[tcm_port_pkg::REGION_EN_BIT]
		: dtcm_ff[tcm_port_pkg::REGION_EN_BIT];
	// One request per two cycles at most, so a held request is not taken twice
	assign take = req_i & ~sel_ff & ~nxt_waiting & region_on;

	// Access phase tracking
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			sel_ff <= 1'b0;
			waiting_ff <= 1'b0;
			last_ff <= 1'b0;
			acc_wr_ff <= 1'b0;
			refused_ff <= 1'b0;
		end else begin
			sel_ff <= take;
			waiting_ff <= nxt_waiting;
			// Read flag latched now: a take on this same edge overwrites acc_wr_ff
			last_ff <= active & ~link.data_mem_wait & ~acc_wr_ff;
			refused_ff <= req_i & ~sel_ff & ~nxt_waiting & ~region_on;
			if (take) begin
				acc_wr_ff <= write_i;
			end
		end
	end

	// Address, lanes and direction live only in the request cycle; zero otherwise
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			addr_ff <= '0;
			bel_ff <= '0;
			dir_ff <= 1'b0;
			seq_ff <= 1'b0;
		end else begin
			addr_ff <= take ? addr_i : '0; // see (R6)
			bel_ff <= take ? lane_mask(byte_offset_i, size_i, big_endian_i) : '0; // see (R6)
			dir_ff <= take & write_i; // see (R6)
			// Held high through waited cycles so loopback wait works
			seq_ff <= take ? seq_i : nxt_waiting; // see (R4)
		end
	end

	// Write data changes only with a new request
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			wd_ff <= '0;
		end else if (take) begin
			wd_ff <= wdata_i; // see (R23)
		end
	end

	// Read data sampled at the end of the final data cycle
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
		end else begin
			rvalid_ff <= last_ff;
			if (last_ff) begin
				rdata_ff <= link.data_read_bus;
			end
		end
	end

	// Region registers; straps are caught while reset is held
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			itcm_ff <= tcm_port_pkg::REGION_RESET;
			itcm_ff[tcm_port_pkg::REGION_EN_BIT] <= boot_imem_enable_pin_i; // see (R13) (R15)
			dtcm_ff <= tcm_port_pkg::REGION_RESET; // see (R16)
			boot_ff <= high_vector_pin_i ? tcm_port_pkg::BOOT_ADDR_HIGH
				: tcm_port_pkg::BOOT_ADDR_LOW; // see (R13) (R14)
		end else if (region_wr_i) begin
			// Whole-word write; clearing the enable bit disables the memory
			if (region_sel_i) begin
				dtcm_ff <= region_wdata_i; // see (R17)
			end else begin
				itcm_ff <= region_wdata_i; // see (R15) (R17)
			end
		end
	end

	assign link.data_mem_select = sel_ff;
	assign link.data_mem_word_addr = addr_ff;
	assign link.data_byte_lane_enables = bel_ff;
	assign link.data_read_write_n = dir_ff;
	assign link.data_write_bus = wd_ff;
	assign link.data_seq_flag = seq_ff;
	assign ack_o = sel_ff;
	assign refused_o = refused_ff;
	assign rvalid_o = rvalid_ff;
	assign rdata_o = rdata_ff;
	assign itcm_region_o = itcm_ff;
	assign dtcm_region_o = dtcm_ff;
	assign boot_addr_o = boot_ff;
endmodule

// *** hw/tcm_link_if.sv ***
// Link between the core-side port and the waited memory subsystem.
// Assumes one shared clock; every signal is active high.
`timescale 1ns/100ps
interface tcm_link_if;
	logic data_mem_select;
	logic [tcm_port_pkg::ADDR_W-1:0] data_mem_word_addr;
	logic [tcm_port_pkg::LANES-1:0] data_byte_lane_enables;
	logic data_read_write_n;
	logic [tcm_port_pkg::DATA_W-1:0] data_write_bus;
	logic data_seq_flag;
	logic [tcm_port_pkg::DATA_W-1:0] data_read_bus;
	logic data_mem_wait;

	modport core (
		output data_mem_select,
		output data_mem_word_addr,
		output data_byte_lane_enables,
		output data_read_write_n,
		output data_write_bus,
		output data_seq_flag,
		input data_read_bus,
		input data_mem_wait
	);

	modport mem (
		input data_mem_select,
		input data_mem_word_addr,
		input data_byte_lane_enables,
		input data_read_write_n,
		input data_write_bus,
		input data_seq_flag,
		output data_read_bus,
		output data_mem_wait
	);
endinterface

// *** hw/tcm_mem_side.sv ***
// Memory end: banked byte-lane RAM, wait generation and DMA arbitration.
// Assumes the core end keeps request attributes only in the request cycle.
// Summary of operation
// (R1) Wait in a cycle governs the next data cycle
// (R2) Core ignores wait when no access is live
// (R3) Optional two-state machine adds one wait always
// (R4) Sequential flag in request, high while waited
// (R5) Inverted sequential flag looped back as wait
// (R6) Attributes valid only in the request cycle
// (R7) One wait input stalls for waits and DMA
// (R8) Postponed request attributes captured for replay
// (R9) Wait combines inverted seq, DMA stall, override
// (R10) Replayed access is forced nonsequential
// (R11) RAM inputs muxed: core, DMA or capture
// (R12) After DMA, replay captured access, one extra wait
// (R13) Boot strap enables instruction memory at zero
// (R14) Strap plus high vectors boots from high address
// (R15) Without strap, software enables instruction memory
// (R16) Data memory enabled only by software
// (R17) Clearing enable bit disables the memory
// (R18) Never-waiting memory holds wait low
// (R19) Four byte lanes share address and select
// (R20) Endian mode decides which lane is least significant
// (R21) Equal banks, low bits shared, high bits gate select
// (R22) Registered bank bits pick returned read data
// (R23) Write data held through waited cycles
`timescale 1ns/100ps
module tcm_mem_side (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	tcm_link_if.mem link,
	input wire logic [1:0] wait_mode_i,
	input wire logic dma_req_i,
	input wire logic dma_write_i,
	input wire logic [tcm_port_pkg::ADDR_W-1:0] dma_addr_i,
	input wire logic [tcm_port_pkg::LANES-1:0] dma_bel_i,
	input wire logic [tcm_port_pkg::DATA_W-1:0] dma_wdata_i,
	output logic dma_grant_o,
	output logic dma_done_o,
	output logic [tcm_port_pkg::DATA_W-1:0] dma_rdata_o
);
	localparam int BW = $clog2(tcm_port_pkg::BANKS);

	logic [tcm_port_pkg::LANE_W-1:0] ram [tcm_port_pkg::BANKS][tcm_port_pkg::LANES]
		[tcm_port_pkg::BANK_DEPTH];
	logic [tcm_port_pkg::DATA_W-1:0] bank_q_ff [tcm_port_pkg::BANKS];
	logic [BW-1:0] bank_sel_ff;
	tcm_port_pkg::wait_state_e ws_ff;
	tcm_port_pkg::dma_state_e dm_ff;
	logic [1:0] dma_cnt_ff;
	logic pend_ff;
	logic cap_wr_ff;
	logic [tcm_port_pkg::ADDR_W-1:0] cap_addr_ff;
	logic [tcm_port_pkg::LANES-1:0] cap_bel_ff;
	logic dma_wr_ff;
	logic [tcm_port_pkg::ADDR_W-1:0] dma_addr_ff;
	logic [tcm_port_pkg::LANES-1:0] dma_bel_ff;
	logic [tcm_port_pkg::DATA_W-1:0] dma_wd_ff;
	logic dma_grant_ff;
	logic dma_done_ff;
	logic [tcm_port_pkg::DATA_W-1:0] dma_rd_ff;
	logic dma_stall;
	logic replay_nonseq_override;
	logic base_wait;
	logic core_cs;
	logic capture;
	logic dma_op;
	logic cs;
	logic wr;
	logic [tcm_port_pkg::ADDR_W-1:0] a;
	logic [tcm_port_pkg::LANES-1:0] bel;
	logic [tcm_port_pkg::DATA_W-1:0] wd;

	// Bank index and offset taken from the word address
	function automatic logic [BW-1:0] bank_of(input logic [tcm_port_pkg::ADDR_W-1:0] ad);
		return ad[tcm_port_pkg::BANK_SEL_LSB +: BW];
	endfunction

	function automatic logic [tcm_port_pkg::BANK_AW-1:0] offs_of(
		input logic [tcm_port_pkg::ADDR_W-1:0] ad);
		return ad[tcm_port_pkg::BANK_AW-1:0];
	endfunction

	// Count value of the first owned cycle, the one that does the RAM access
	function automatic logic [1:0] dma_first();
		return tcm_port_pkg::DMA_CYCLES - 2'h1;
	endfunction

	// Wait sources; the wait is combinational because it must answer in the
	// request cycle itself, so this end cannot present it from a flip-flop
	assign dma_stall = (dm_ff == tcm_port_pkg::DM_OWN);
	assign replay_nonseq_override = (dm_ff == tcm_port_pkg::DM_REPLAY); // see (R10)
	always_comb begin
		case (wait_mode_i)
			tcm_port_pkg::MODE_FIXED: base_wait = (ws_ff == tcm_port_pkg::WS_WAIT); // see (R3)
			tcm_port_pkg::MODE_SEQ: base_wait = ~link.data_seq_flag; // see (R5)
			default: base_wait = 1'b0; // see (R18)
		endcase
	end
	// Driven every cycle, so idle-cycle values are speculative
	assign link.data_mem_wait = base_wait | dma_stall | replay_nonseq_override; // see (R1) (R7) (R9)

	// Fixed single wait: flip to complete on a request, back to wait after
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			ws_ff <= tcm_port_pkg::WS_WAIT;
		end else begin
			case (ws_ff)
				tcm_port_pkg::WS_WAIT: begin
					if (link.data_mem_select) begin
						ws_ff <= tcm_port_pkg::WS_COMPLETE; // see (R3)
					end
				end
				tcm_port_pkg::WS_COMPLETE: ws_ff <= tcm_port_pkg::WS_WAIT; // see (R3)
				default: ws_ff <= tcm_port_pkg::WS_WAIT;
			endcase
		end
	end

	// DMA ownership: fixed-length access, then replay of any postponed request
	assign capture = link.data_mem_select & dma_stall;
	assign dma_op = dma_stall & (dma_cnt_ff == dma_first());
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			dm_ff <= tcm_port_pkg::DM_IDLE;
			dma_cnt_ff <= '0;
			pend_ff <= 1'b0;
			dma_grant_ff <= 1'b0;
		end else begin
			dma_grant_ff <= 1'b0;
			case (dm_ff)
				tcm_port_pkg::DM_IDLE: begin
					if (dma_req_i) begin
						dm_ff <= tcm_port_pkg::DM_OWN;
						dma_cnt_ff <= dma_first();
						dma_grant_ff <= 1'b1;
					end
				end
				tcm_port_pkg::DM_OWN: begin
					if (capture) begin
						pend_ff <= 1'b1;
					end
					if (dma_cnt_ff == tcm_port_pkg::DMA_LAST) begin
						// Replay holds wait one more cycle before completion
						dm_ff <= (pend_ff | capture) ? tcm_port_pkg::DM_REPLAY
							: tcm_port_pkg::DM_IDLE; // see (R12)
					end else begin
						dma_cnt_ff <= dma_cnt_ff - 2'h1;
					end
				end
				tcm_port_pkg::DM_REPLAY: begin
					pend_ff <= 1'b0;
					dm_ff <= tcm_port_pkg::DM_IDLE;
				end
				default: dm_ff <= tcm_port_pkg::DM_IDLE;
			endcase
		end
	end

	// Postponed request captured at the end of its request cycle
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			cap_wr_ff <= 1'b0;
			cap_addr_ff <= '0;
			cap_bel_ff <= '0;
		end else if (capture) begin
			cap_wr_ff <= link.data_read_write_n; // see (R8)
			cap_addr_ff <= link.data_mem_word_addr; // see (R8)
			cap_bel_ff <= link.data_byte_lane_enables; // see (R8)
		end
	end

	// DMA attributes held for the whole ownership
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			dma_wr_ff <= 1'b0;
			dma_addr_ff <= '0;
			dma_bel_ff <= '0;
			dma_wd_ff <= '0;
		end else if (dm_ff == tcm_port_pkg::DM_IDLE && dma_req_i) begin
			dma_wr_ff <= dma_write_i;
			dma_addr_ff <= dma_addr_i;
			dma_bel_ff <= dma_bel_i;
			dma_wd_ff <= dma_wdata_i;
		end
	end

	// RAM input mux; core write data stays valid, so replay uses it live
	assign core_cs = link.data_mem_select & ~dma_stall;
	always_comb begin
		cs = core_cs;
		wr = link.data_read_write_n;
		a = link.data_mem_word_addr;
		bel = link.data_byte_lane_enables;
		wd = link.data_write_bus;
		if (dma_op) begin
			cs = 1'b1;
			wr = dma_wr_ff;
			a = dma_addr_ff;
			bel = dma_bel_ff;
			wd = dma_wd_ff; // see (R11)
		end else if (replay_nonseq_override) begin
			cs = 1'b1;
			wr = cap_wr_ff;
			a = cap_addr_ff;
			bel = cap_bel_ff; // see (R11) (R12)
		end
	end

	// Per-bank select gated by the upper bits, lanes keyed by byte enable
	always_ff @(posedge clock_i) begin
		for (int b = 0; b < tcm_port_pkg::BANKS; b++) begin
			if (cs && wr && bank_of(a) == BW'(b)) begin // see (R21)
				for (int k = 0; k < tcm_port_pkg::LANES; k++) begin
					if (bel[k]) begin
						ram[b][k][offs_of(a)] <= wd[k*tcm_port_pkg::LANE_W +: tcm_port_pkg::LANE_W]; // see (R19)
					end
				end
			end
		end
	end

	// Core read data per bank; DMA reads leave these untouched
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			bank_sel_ff <= '0;
			for (int b = 0; b < tcm_port_pkg::BANKS; b++) begin
				bank_q_ff[b] <= '0;
			end
		end else if (cs && !dma_op && !wr) begin
			bank_sel_ff <= bank_of(a); // see (R22)
			for (int b = 0; b < tcm_port_pkg::BANKS; b++) begin
				if (bank_of(a) == BW'(b)) begin // see (R21)
					for (int k = 0; k < tcm_port_pkg::LANES; k++) begin
						bank_q_ff[b][k*tcm_port_pkg::LANE_W +: tcm_port_pkg::LANE_W] <=
							ram[b][k][offs_of(a)]; // see (R19)
					end
				end
			end
		end
	end
	assign link.data_read_bus = bank_q_ff[bank_sel_ff]; // see (R22)

	// DMA read data and completion pulse
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			dma_done_ff <= 1'b0;
			dma_rd_ff <= '0;
		end else begin
			dma_done_ff <= dma_op;
			if (dma_op && !dma_wr_ff) begin
				for (int k = 0; k < tcm_port_pkg::LANES; k++) begin
					dma_rd_ff[k*tcm_port_pkg::LANE_W +: tcm_port_pkg::LANE_W] <=
						ram[bank_of(a)][k][offs_of(a)];
				end
			end
		end
	end

	assign dma_grant_o = dma_grant_ff;
	assign dma_done_o = dma_done_ff;
	assign dma_rdata_o = dma_rd_ff;
endmodule

// *** hw/tcm_port_pkg.sv ***
// Shared constants for the waited tightly coupled memory port.
// Assumes both ends and the interface are compiled after this package.
package tcm_port_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	// Memory built from equal banks, bank index above the bank offset
	localparam int BANKS = 2;
	localparam int BANK_AW = 8;
	localparam int BANK_DEPTH = 256;
	localparam int BANK_SEL_LSB = 8;
	// Region register layout
	localparam int REGION_EN_BIT = 0;
	localparam logic [31:0] REGION_RESET = 32'h0000_0000;
	localparam logic [31:0] BOOT_ADDR_LOW = 32'h0000_0000;
	localparam logic [31:0] BOOT_ADDR_HIGH = 32'h0fff_0000;
	// Wait generation modes of the memory end
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_FIXED = 2'h1;
	localparam logic [1:0] MODE_SEQ = 2'h2;
	// Access sizes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [3:0] MASK_BYTE = 4'h1;
	localparam logic [3:0] MASK_HALF = 4'h3;
	localparam logic [3:0] MASK_WORD = 4'hf;
	// Cycles one DMA access owns the memory
	localparam logic [1:0] DMA_CYCLES = 2'h2;
	localparam logic [1:0] DMA_LAST = 2'h0;

	typedef enum logic {
		WS_WAIT = 1'b0,
		WS_COMPLETE = 1'b1
	} wait_state_e;

	typedef enum logic [1:0] {
		DM_IDLE = 2'b00,
		DM_OWN = 2'b01,
		DM_REPLAY = 2'b11
	} dma_state_e;
endpackage

// *** tb/tcm_wait_dma_memory_port_asserts.sv ***
// Concurrent checks on the link between the core end and the memory end.
// Assumes one clock_i domain and a synchronous active-high sys_rst_i.
`timescale 1ns/100ps
module tcm_wait_dma_memory_port_asserts (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic data_mem_select,
	input wire logic [tcm_port_pkg::ADDR_W-1:0] data_mem_word_addr,
	input wire logic [tcm_port_pkg::LANES-1:0] data_byte_lane_enables,
	input wire logic data_read_write_n,
	input wire logic [tcm_port_pkg::DATA_W-1:0] data_write_bus,
	input wire logic data_seq_flag,
	input wire logic [tcm_port_pkg::DATA_W-1:0] data_read_bus,
	input wire logic data_mem_wait
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);

	// Attributes are zeroed outside the request cycle
	a_attr_idle_zero: assert property (
		!data_mem_select |-> data_mem_word_addr == '0 && data_byte_lane_enables == '0
		&& !data_read_write_n) else $error("attributes live outside request cycle");
	// A waited request is followed by a waited data cycle flagged sequential
	a_seq_after_wait: assert property (
		data_mem_select && data_mem_wait |=> data_seq_flag && !data_mem_select)
		else $error("sequential flag low in first waited cycle");
	a_seq_chain_wait: assert property (
		!data_mem_select && data_seq_flag && data_mem_wait |=> data_seq_flag && !data_mem_select)
		else $error("sequential flag dropped during waits");
	// Outside requests the flag only shows a waited data cycle
	a_seq_only_waited: assert property (
		data_seq_flag && !data_mem_select |-> $past(data_mem_wait)
		&& ($past(data_mem_select) || $past(data_seq_flag)))
		else $error("sequential flag high outside waited cycle");
	a_wdata_hold_wait: assert property (
		data_mem_select && data_mem_wait |=> $stable(data_write_bus))
		else $error("write data moved in waited cycle");
	a_wdata_new_req: assert property (
		$changed(data_write_bus) |-> data_mem_select)
		else $error("write data changed without request");
	// Stores light only the legal contiguous lane groups
	a_lane_mask_legal: assert property (
		data_mem_select && data_read_write_n |-> data_byte_lane_enables inside
		{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf}) else $error("illegal lane mask");
	// Wait in the request cycle must be seen before the next request
	a_req_spaced: assert property (
		data_mem_select |=> !data_mem_select) else $error("back to back request cycles");

	// Main scenarios
	c_waited_req: cover property (data_mem_select && data_mem_wait ##1 data_mem_wait);
	c_seq_no_wait: cover property (data_mem_select && data_seq_flag && !data_mem_wait);
	c_top_lane: cover property (data_mem_select && data_byte_lane_enables == 4'h8);
endmodule

// *** tb/tcm_wait_dma_memory_port_tb.sv ***
// Self-checking bench joining the core end and memory end over the link.
// Assumes the package and interface are compiled first; 25 MHz clock.
`timescale 1ns/100ps
module tcm_wait_dma_memory_port_tb;
	logic clock_i, sys_rst_i, boot_imem_enable_pin_i, high_vector_pin_i, big_endian_i;
	logic instr_side_i, req_i, write_i, seq_i, region_wr_i, region_sel_i;
	logic ack_o, refused_o, rvalid_o, dma_req_i, dma_write_i, dma_grant_o, dma_done_o;
	logic [1:0] byte_offset_i, size_i, wait_mode_i;
	logic [3:0] dma_bel_i;
	logic [17:0] addr_i, dma_addr_i;
	logic [31:0] wdata_i, region_wdata_i, dma_wdata_i, dma_rdata_o, rdata_o;
	logic [31:0] itcm_region_o, dtcm_region_o, boot_addr_o;
	logic [31:0] model [512];
	logic [15:0] rnd;
	int fails, checked;

	tcm_link_if link();
	tcm_core_port i_tcm_core_port (.clock_i, .sys_rst_i, .link(link), .boot_imem_enable_pin_i,
		.high_vector_pin_i, .big_endian_i, .instr_side_i, .req_i, .write_i, .seq_i, .addr_i,
		.byte_offset_i, .size_i, .wdata_i, .region_wr_i, .region_sel_i, .region_wdata_i,
		.ack_o, .refused_o, .rvalid_o, .rdata_o, .itcm_region_o, .dtcm_region_o, .boot_addr_o);
	tcm_mem_side i_tcm_mem_side (.clock_i, .sys_rst_i, .link(link), .wait_mode_i, .dma_req_i,
		.dma_write_i, .dma_addr_i, .dma_bel_i, .dma_wdata_i, .dma_grant_o, .dma_done_o,
		.dma_rdata_o);
	tcm_wait_dma_memory_port_asserts i_tcm_wait_dma_memory_port_asserts (.clock_i, .sys_rst_i,
		.data_mem_select(link.data_mem_select), .data_mem_word_addr(link.data_mem_word_addr),
		.data_byte_lane_enables(link.data_byte_lane_enables),
		.data_read_write_n(link.data_read_write_n), .data_write_bus(link.data_write_bus),
		.data_seq_flag(link.data_seq_flag), .data_read_bus(link.data_read_bus),
		.data_mem_wait(link.data_mem_wait));

	// Free-running 25 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Lanes a store lights; big endian mirrors the little-endian mask
	function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] of, input logic be);
		logic [3:0] m;
		m = (sz == tcm_port_pkg::SIZE_BYTE) ? tcm_port_pkg::MASK_BYTE :
			(sz == tcm_port_pkg::SIZE_HALF) ? tcm_port_pkg::MASK_HALF : tcm_port_pkg::MASK_WORD;
		m = m << of;
		return be ? {m[0], m[1], m[2], m[3]} : m;
	endfunction
	// Edges from ack to read done: one more when the request cycle waits
	function automatic int read_lat(input logic [1:0] md, input logic sq);
		return (md == 2'h0 || (md == 2'h2 && sq)) ? 2 : 3;
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic do_reset(input logic bp, input logic hv, input int cyc);
		sys_rst_i <= 1'b1;
		boot_imem_enable_pin_i <= bp;
		high_vector_pin_i <= hv;
		repeat (cyc) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic region(input logic s, input logic [31:0] v);
		region_wr_i <= 1'b1;
		region_sel_i <= s;
		region_wdata_i <= v;
		@(posedge clock_i);
		region_wr_i <= 1'b0;
		@(posedge clock_i);
	endtask

	// Request is held until ack or refusal; one spare edge avoids re-driving req_i
	task automatic core_op(input logic w, input logic sq, input logic [8:0] a, input logic [1:0] of,
		input logic [1:0] sz, input logic [31:0] d, output int lat, output logic refd);
		int n;
		n = 0;
		lat = 0;
		req_i <= 1'b1;
		write_i <= w;
		seq_i <= sq;
		addr_i <= {9'h0, a};
		byte_offset_i <= of;
		size_i <= sz;
		wdata_i <= d;
		do begin
			@(posedge clock_i);
			n++;
		end while (ack_o !== 1'b1 && refused_o !== 1'b1 && n < 40);
		refd = refused_o;
		req_i <= 1'b0;
		if (!w && refd === 1'b0) begin
			do begin
				@(posedge clock_i);
				lat++;
			end while (rvalid_o !== 1'b1 && lat < 40);
		end
		if (n >= 40 || lat >= 40) fails++;
		@(posedge clock_i);
	endtask

	task automatic dma_op(input logic w, input logic [8:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		int n;
		n = 0;
		dma_req_i <= 1'b1;
		dma_write_i <= w;
		dma_addr_i <= {9'h0, a};
		dma_bel_i <= 4'hf;
		dma_wdata_i <= d;
		do begin
			@(posedge clock_i);
			n++;
		end while (dma_grant_o !== 1'b1 && n < 40);
		dma_req_i <= 1'b0;
		do begin
			@(posedge clock_i);
			n++;
		end while (dma_done_o !== 1'b1 && n < 80);
		rd = dma_rdata_o;
		if (n >= 80) fails++;
		@(posedge clock_i);
	endtask

	// Hang guard, far beyond the several hundred cycles the run needs
	initial begin
		repeat (6000) @(posedge clock_i);
		fails++;
		finish_test();
	end

	initial begin
		int lat;
		logic refd;
		logic [8:0] a, pa;
		logic [3:0] m;
		logic [1:0] sz, of;
		logic [31:0] d, rd;
		fails = 0;
		checked = 0;
		rnd = 16'h0042;
		{sys_rst_i, boot_imem_enable_pin_i, high_vector_pin_i, big_endian_i} = 4'h8;
		{instr_side_i, req_i, write_i, seq_i, region_wr_i, region_sel_i} = 6'h0;
		{byte_offset_i, size_i, wait_mode_i, dma_bel_i, addr_i, dma_addr_i} = '0;
		{wdata_i, region_wdata_i, dma_wdata_i, dma_req_i, dma_write_i} = '0;
		// Every strap combination, straps sampled while reset is high
		for (int i = 0; i < 4; i++) begin
			do_reset(i[0], i[1], 10);
			check("itcm", itcm_region_o, {31'h0, i[0]});
			check("boot", boot_addr_o, i[1] ? tcm_port_pkg::BOOT_ADDR_HIGH
				: tcm_port_pkg::BOOT_ADDR_LOW);
			check("dtcm", dtcm_region_o, 32'h0);
		end
		instr_side_i <= 1'b1;
		core_op(1'b0, 1'b0, 9'h0, 2'h0, tcm_port_pkg::SIZE_WORD, 32'h0, lat, refd);
		check("boot fetch refused", {31'h0, refd}, 32'h0);
		instr_side_i <= 1'b0;
		core_op(1'b0, 1'b0, 9'h0, 2'h0, tcm_port_pkg::SIZE_WORD, 32'h0, lat, refd);
		check("data refused", {31'h0, refd}, 32'h1);
		do_reset(1'b0, 1'b0, 3);
		instr_side_i <= 1'b1;
		core_op(1'b0, 1'b0, 9'h0, 2'h0, tcm_port_pkg::SIZE_WORD, 32'h0, lat, refd);
		check("instr refused", {31'h0, refd}, 32'h1);
		region(1'b0, 32'h1);
		core_op(1'b0, 1'b0, 9'h0, 2'h0, tcm_port_pkg::SIZE_WORD, 32'h0, lat, refd);
		check("instr enabled", {31'h0, refd}, 32'h0);
		instr_side_i <= 1'b0;
		region(1'b1, 32'h1);
		region(1'b1, 32'h0);
		core_op(1'b0, 1'b0, 9'h0, 2'h0, tcm_port_pkg::SIZE_WORD, 32'h0, lat, refd);
		check("cleared refused", {31'h0, refd}, 32'h1);
		region(1'b1, 32'h1);
		check("dtcm on", dtcm_region_o, 32'h1);
		// Random word and sub-word stores, read back across both banks in every wait mode
		for (int md = 0; md < 3; md++) begin
			wait_mode_i <= md[1:0];
			pa = 9'h0;
			for (int k = 0; k < 6; k++) begin
				rnd = lfsr(rnd);
				a = rnd[8:0];
				rnd = lfsr(rnd);
				d = {rnd, rnd ^ 16'h5a3c};
				core_op(1'b1, 1'b0, a, 2'h0, tcm_port_pkg::SIZE_WORD, d, lat, refd);
				model[a] = d;
				rnd = lfsr(rnd);
				sz = {1'b0, rnd[0]};
				of = rnd[0] ? {rnd[2], 1'b0} : rnd[2:1];
				m = lanes(sz, of, rnd[3]);
				big_endian_i <= rnd[3];
				d = {rnd, ~rnd};
				core_op(1'b1, 1'b0, a, of, sz, d, lat, refd);
				for (int b = 0; b < 4; b++) begin
					if (m[b]) model[a][8*b +: 8] = d[8*b +: 8];
				end
				core_op(1'b0, 1'b0, a, 2'h0, tcm_port_pkg::SIZE_WORD, 32'h0, lat, refd);
				check("lane data", rdata_o, model[a]);
				check("read latency", 32'(lat), 32'(read_lat(md[1:0], 1'b0)));
				if (k > 0) begin
					core_op(1'b0, 1'b1, pa, 2'h0, tcm_port_pkg::SIZE_WORD, 32'h0, lat, refd);
					check("bank data", rdata_o, model[pa]);
					check("seq latency", 32'(lat), 32'(read_lat(md[1:0], 1'b1)));
				end
				pa = a;
			end
		end
		// DMA in sequential-loopback mode: plain, then colliding with core requests
		big_endian_i <= 1'b0;
		dma_op(1'b1, 9'h0a5, 32'hc0de_1234, rd);
		model[9'h0a5] = 32'hc0de_1234;
		core_op(1'b1, 1'b0, 9'h15a, 2'h0, tcm_port_pkg::SIZE_WORD, 32'h8bad_f00d, lat, refd);
		model[9'h15a] = 32'h8bad_f00d;
		dma_op(1'b0, 9'h15a, 32'h0, rd);
		check("dma read", rd, 32'h8bad_f00d);
		fork
			core_op(1'b0, 1'b1, 9'h0a5, 2'h0, tcm_port_pkg::SIZE_WORD, 32'h0, lat, refd);
			dma_op(1'b1, 9'h0c3, 32'h7e57_0001, rd);
		join
		check("replay data", rdata_o, 32'hc0de_1234);
		check("replay latency", 32'(lat), 32'h5);
		fork
			core_op(1'b1, 1'b1, 9'h15a, 2'h3, tcm_port_pkg::SIZE_BYTE, 32'h5500_0000, lat, refd);
			dma_op(1'b0, 9'h0a5, 32'h0, rd);
		join
		check("dma under core", rd, 32'hc0de_1234);
		core_op(1'b0, 1'b0, 9'h15a, 2'h0, tcm_port_pkg::SIZE_WORD, 32'h0, lat, refd);
		check("replayed store", rdata_o, 32'h55ad_f00d);
		core_op(1'b0, 1'b0, 9'h0c3, 2'h0, tcm_port_pkg::SIZE_WORD, 32'h0, lat, refd);
		check("dma store", rdata_o, 32'h7e57_0001);
		finish_test();
	end
endmodule
